// File: src/aris_pkg.sv
/*
 * aris_pkg: register map, field layout, reset values and decode types for the
 * converter result formatter and input-select block.
 * assumes: byte addresses on a 32-bit AHB-Lite bus, one register per word.
 */
`default_nettype none

package aris_pkg;

    // register byte offsets
    localparam logic [7:0] ARIS_OFF_RESULT_LOW   = 8'h70;
    localparam logic [7:0] ARIS_OFF_RESULT_HIGH  = 8'h74;
    localparam logic [7:0] ARIS_OFF_INPUT_SELECT = 8'h7c;
    localparam logic [7:0] ARIS_OFF_CONTROL      = 8'h80;
    localparam logic [7:0] ARIS_OFF_IRQ_STATUS   = 8'h84;
    localparam logic [7:0] ARIS_OFF_IRQ_ENABLE   = 8'h88;
    localparam logic [7:0] ARIS_OFF_IRQ_CLEAR    = 8'h8c;

    // converter_input_select fields
    localparam int ARIS_REF_MSB  = 7;
    localparam int ARIS_REF_LSB  = 6;
    localparam int ARIS_ADJ_BIT  = 5;
    localparam int ARIS_CHAN_MSB = 4;

    // control and status fields
    localparam int ARIS_START_BIT = 0;
    localparam int ARIS_DONE_BIT  = 0;

    // reset values
    localparam logic [7:0] ARIS_INPUT_SELECT_RST = 8'h00;
    localparam logic [9:0] ARIS_RESULT_RST       = 10'h000;

    // code limits on the 12-bit signed raw value from the analog core
    localparam logic signed [11:0] ARIS_SE_MIN   = 12'sh000;
    localparam logic signed [11:0] ARIS_SE_MAX   = 12'sh3ff;
    localparam logic signed [11:0] ARIS_DIFF_MIN = 12'she00;
    localparam logic signed [11:0] ARIS_DIFF_MAX = 12'sh1ff;

    // single-ended selections beyond the eight pins
    localparam logic [3:0] ARIS_IN_BANDGAP = 4'h8;
    localparam logic [3:0] ARIS_IN_GROUND  = 4'h9;
    localparam logic [4:0] ARIS_CODE_BANDGAP = 5'h1e;
    localparam logic [4:0] ARIS_CODE_GROUND  = 5'h1f;

    typedef enum logic [1:0] {
        ARIS_REF_EXT_PIN  = 2'h0,
        ARIS_REF_SUPPLY   = 2'h1,
        ARIS_REF_INT_1V1  = 2'h2,
        ARIS_REF_INT_2V56 = 2'h3
    } aris_ref_t;

    typedef enum logic [1:0] {
        ARIS_GAIN_1X   = 2'h0,
        ARIS_GAIN_10X  = 2'h1,
        ARIS_GAIN_200X = 2'h2
    } aris_gain_t;

    typedef struct packed {
        logic       diff;
        logic [3:0] pos;
        logic [3:0] neg;
        aris_gain_t gain;
    } aris_route_t;

    typedef enum logic [3:0] {
        ARIS_BUS_IDLE = 4'b0001,
        ARIS_BUS_WR   = 4'b0010,
        ARIS_BUS_RDW  = 4'b0100,
        ARIS_BUS_RDD  = 4'b1000
    } aris_bus_t;

endpackage : aris_pkg

`default_nettype wire

// File: src/aris_top.sv
/*
 * aris_top: digital side of a 10-bit converter. formats results into two
 * result bytes, holds the input-select register, applies reference and
 * channel changes only between conversions, and raises a done interrupt.
 * assumes: the analog core runs on hclk, takes conv_start as a one-cycle
 * pulse and answers with a one-cycle conv_done_in and a signed raw value.
 */
// Chosen here: the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none

module aris_top
    import aris_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        ce,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        conv_done_in,
    input  wire logic [11:0] conv_raw,
    output logic             conv_start,
    output aris_ref_t        ref_source,
    output logic             internal_ref_on,
    output logic             diff_mode,
    output logic      [3:0]  pos_input,
    output logic      [3:0]  neg_input,
    output aris_gain_t       gain,
    output logic             busy,
    output logic             irq
);

    ////////////////////////////////////////////////////////////////////////
    // decode helpers

    // channel/gain code to input routing; pairs with equal pins are legal
    function automatic aris_route_t route_of(input logic [4:0] code);
        aris_route_t r;
        r = '{diff: 1'b0, pos: {1'b0, code[2:0]}, neg: 4'h0, gain: ARIS_GAIN_1X};
        case (code[4:3])
            2'b00: begin
                r.diff = 1'b0;
            end
            2'b01: begin
                r.diff = 1'b1;
                r.pos  = {2'b00, code[2], code[0]};
                r.neg  = {2'b00, code[2], 1'b0};
                r.gain = code[1] ? ARIS_GAIN_200X : ARIS_GAIN_10X;
            end
            2'b10: begin
                r.diff = 1'b1;
                r.neg  = 4'h1;
            end
            default: begin
                if (code == ARIS_CODE_BANDGAP) begin
                    r.pos = ARIS_IN_BANDGAP;
                end else if (code == ARIS_CODE_GROUND) begin
                    r.pos = ARIS_IN_GROUND;
                end else begin
                    r.diff = 1'b1;
                    r.neg  = 4'h2;
                end
            end
        endcase
        return r;
    endfunction : route_of

    // clamp the raw analog value into the 10-bit code of the mode in use
    function automatic logic [9:0] saturate(input logic signed [11:0] raw,
                                            input logic               is_diff);
        logic signed [11:0] lo;
        logic signed [11:0] hi;
        logic signed [11:0] v;
        lo = is_diff ? ARIS_DIFF_MIN : ARIS_SE_MIN;
        hi = is_diff ? ARIS_DIFF_MAX : ARIS_SE_MAX;
        v  = raw;
        if (raw < lo) begin
            v = lo;
        end else if (raw > hi) begin
            v = hi;
        end
        return v[9:0];
    endfunction : saturate

    // byte presentation of the stored result
    function automatic logic [7:0] present(input logic [9:0] res,
                                           input logic       left,
                                           input logic       high);
        logic [7:0] b;
        if (left) begin
            b = high ? res[9:2] : {res[1:0], 6'h00};
        end else begin
            b = high ? {6'h00, res[9:8]} : res[7:0];
        end
        return b;
    endfunction : present

    ////////////////////////////////////////////////////////////////////////
    // bus slave

    aris_bus_t   bus_state_r;
    logic [7:0]  addr_r;
    logic [31:0] hrdata_r;
    logic        addr_take;
    logic        wr_fire;
    logic        rd_sample;

    logic [7:0]  input_select_r;
    logic [9:0]  result_r;
    logic        status_r;
    logic        enable_r;
    logic        busy_r;
    logic        conv_start_r;
    aris_ref_t   ref_applied_r;
    logic [4:0]  chan_applied_r;
    logic        start_req;
    logic        clear_req;
    logic        done_evt;
    aris_route_t route;

    assign addr_take = ce && hsel && hready && htrans[1];
    assign wr_fire   = ce && (bus_state_r == ARIS_BUS_WR);
    assign rd_sample = ce && (bus_state_r == ARIS_BUS_RDW);

    // reads take one wait state so a write just before is already visible
    assign hreadyout = ce && (bus_state_r != ARIS_BUS_RDW);
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_state_r <= ARIS_BUS_IDLE;
            addr_r      <= 8'h00;
        end else if (ce) begin
            case (bus_state_r)
                ARIS_BUS_RDW: begin
                    bus_state_r <= ARIS_BUS_RDD;
                end
                default: begin
                    if (addr_take) begin
                        addr_r      <= haddr[7:0];
                        bus_state_r <= hwrite ? ARIS_BUS_WR : ARIS_BUS_RDW;
                    end else begin
                        bus_state_r <= ARIS_BUS_IDLE;
                    end
                end
            endcase
        end
    end

    // read mux; unmapped offsets and unused bits read zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= 32'h0000_0000;
        end else if (rd_sample) begin
            hrdata_r <= 32'h0000_0000;
            case (addr_r)
                ARIS_OFF_RESULT_LOW: begin
                    hrdata_r[7:0] <= present(result_r, input_select_r[ARIS_ADJ_BIT],
                                             1'b0);
                end
                ARIS_OFF_RESULT_HIGH: begin
                    hrdata_r[7:0] <= present(result_r, input_select_r[ARIS_ADJ_BIT],
                                             1'b1);
                end
                ARIS_OFF_INPUT_SELECT: begin
                    hrdata_r[7:0] <= input_select_r;
                end
                ARIS_OFF_CONTROL: begin
                    hrdata_r[ARIS_START_BIT] <= busy_r;
                end
                ARIS_OFF_IRQ_STATUS: begin
                    hrdata_r[ARIS_DONE_BIT] <= status_r;
                end
                ARIS_OFF_IRQ_ENABLE: begin
                    hrdata_r[ARIS_DONE_BIT] <= enable_r;
                end
                default: begin
                    hrdata_r <= 32'h0000_0000;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // software registers

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            input_select_r <= ARIS_INPUT_SELECT_RST;
        end else if (wr_fire && addr_r == ARIS_OFF_INPUT_SELECT) begin
            input_select_r <= hwdata[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            enable_r <= 1'b0;
        end else if (wr_fire && addr_r == ARIS_OFF_IRQ_ENABLE) begin
            enable_r <= hwdata[ARIS_DONE_BIT];
        end
    end

    assign start_req = wr_fire && (addr_r == ARIS_OFF_CONTROL) && hwdata[ARIS_START_BIT]
                       && !busy_r;
    assign clear_req = wr_fire && (addr_r == ARIS_OFF_IRQ_CLEAR) && hwdata[ARIS_DONE_BIT];

    ////////////////////////////////////////////////////////////////////////
    // conversion sequencing

    assign done_evt = ce && busy_r && conv_done_in;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy_r       <= 1'b0;
            conv_start_r <= 1'b0;
        end else if (ce) begin
            conv_start_r <= start_req;
            if (start_req) begin
                busy_r <= 1'b1;
            end else if (done_evt) begin
                busy_r <= 1'b0;
            end
        end
    end

    // routing follows the register only while idle or as a conversion ends
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ref_applied_r  <= ARIS_REF_EXT_PIN;
            chan_applied_r <= 5'h00;
        end else if (ce && (!busy_r || done_evt)) begin
            ref_applied_r  <= aris_ref_t'(input_select_r[ARIS_REF_MSB:ARIS_REF_LSB]);
            chan_applied_r <= input_select_r[ARIS_CHAN_MSB:0];
        end
    end

    // result capture uses the routing that was in force for this conversion
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            result_r <= ARIS_RESULT_RST;
        end else if (done_evt) begin
            result_r <= saturate(conv_raw, route.diff);
        end
    end

    // done flag: a completion in the same cycle as a clear keeps the flag set
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_r <= 1'b0;
        end else if (done_evt) begin
            status_r <= 1'b1;
        end else if (clear_req) begin
            status_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs to the analog core

    assign route = route_of(chan_applied_r);

    assign conv_start      = conv_start_r;
    assign ref_source      = ref_applied_r;
    assign internal_ref_on = (ref_applied_r == ARIS_REF_INT_1V1) ||
                             (ref_applied_r == ARIS_REF_INT_2V56);
    assign diff_mode       = route.diff;
    assign pos_input       = route.pos;
    assign neg_input       = route.neg;
    assign gain            = route.gain;
    assign busy            = busy_r;
    assign irq             = status_r && enable_r;

    logic unused_ok;
    assign unused_ok = ^{hsize, haddr[31:8], hwdata[31:8]};

endmodule : aris_top

`default_nettype wire

// File: test/aris_props.sv
/* aris_props: port checker for aris_top, bound below.
   assumes: one hclk domain, ce dropped by the bench only while the bus is idle. */
`timescale 1ns/10ps
`default_nettype none

module aris_props
    import aris_pkg::*;
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        ce,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        conv_done_in,
    input wire logic        conv_start,
    input wire aris_ref_t   ref_source,
    input wire logic        internal_ref_on,
    input wire logic        diff_mode,
    input wire logic [3:0]  pos_input,
    input wire logic [3:0]  neg_input,
    input wire aris_gain_t  gain,
    input wire logic        busy,
    input wire logic        irq
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_START_BUSY: assert property (ce && conv_start |-> busy)
        else $error("start pulse without busy");
    AST_START_ONE: assert property (ce && conv_start |=> !conv_start)
        else $error("start pulse longer than one cycle");
    AST_DONE_IDLE: assert property (ce && busy && conv_done_in |=> !busy)
        else $error("busy stays after done");
    AST_REF_HOLD: assert property (ce && busy && !conv_done_in |=> $stable(ref_source))
        else $error("reference moved mid conversion");
    AST_ROUTE_HOLD: assert property (ce && busy && !conv_done_in
        |=> $stable({diff_mode, pos_input, neg_input, gain}))
        else $error("routing moved mid conversion");
    AST_INT_REF: assert property (internal_ref_on == ref_source[1])
        else $error("internal reference enable wrong");
    AST_SE_GAIN: assert property (!diff_mode |-> gain == ARIS_GAIN_1X)
        else $error("gain not unity in single ended");
    AST_WR_NOWAIT: assert property (ce && hsel && hready && htrans[1] && hwrite
        |=> hreadyout)
        else $error("write data phase stalled");
    AST_RD_WAIT: assert property (ce && hsel && hready && htrans[1] && !hwrite
        |=> !hreadyout ##1 hreadyout)
        else $error("read wait cycle wrong");
    AST_OKAY: assert property (hresp == 1'b0)
        else $error("response not okay");
    AST_CE_STALL: assert property (!ce |-> !hreadyout)
        else $error("bus ready while clock enable low");

    cover property (conv_start);
    cover property (busy && conv_done_in);
    cover property (irq);
endmodule : aris_props

bind aris_top aris_props chk_u (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .conv_done_in(conv_done_in), .conv_start(conv_start),
    .ref_source(ref_source), .internal_ref_on(internal_ref_on), .diff_mode(diff_mode),
    .pos_input(pos_input), .neg_input(neg_input), .gain(gain), .busy(busy), .irq(irq));

`default_nettype wire

// File: test/aris_analog_model.sv
/* aris_analog_model: analog core stand-in, answers a start dly+1 cycles after the edge that samples it.
   assumes: the bench sets dly and val before each start. */
`timescale 1ns/10ps
`default_nettype none

module aris_analog_model (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        conv_start,
    input  wire logic [7:0]  dly,
    input  wire logic [11:0] val,
    output logic             conv_done_in,
    output logic      [11:0] conv_raw
);
    logic       run_r;
    logic [7:0] cnt_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run_r        <= 1'b0;
            cnt_r        <= 8'h00;
            conv_done_in <= 1'b0;
            conv_raw     <= 12'h5a5;
        end else begin
            conv_done_in <= 1'b0;
            // raw value is only meaningful with the done pulse
            conv_raw     <= ~conv_raw;
            if (conv_start) begin
                run_r <= 1'b1;
                cnt_r <= dly;
            end else if (run_r && cnt_r == 8'h00) begin
                run_r        <= 1'b0;
                conv_done_in <= 1'b1;
                conv_raw     <= val;
            end else if (run_r) begin
                cnt_r <= cnt_r - 8'h01;
            end
        end
    end
endmodule : aris_analog_model

`default_nettype wire

// File: test/aris_tb_top.sv
/* aris_tb_top: register-level tests of aris_top over AHB-Lite.
   assumes: aris_props bound, analog model on the same clock. */
`timescale 1ns/10ps
`default_nettype none

module aris_tb_top
    import aris_pkg::*;
;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        ce = 1'b1;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [7:0]  dly = 8'h03;
    logic [11:0] val = 12'h000;
    wire logic [31:0] hrdata;
    wire logic        hreadyout, hresp, conv_done_in, conv_start;
    wire logic [11:0] conv_raw;
    wire aris_ref_t   ref_source;
    wire aris_gain_t  gain;
    wire logic        internal_ref_on, diff_mode, busy, irq;
    wire logic [3:0]  pos_input, neg_input;
    int error_cnt = 0;
    int samples_checked = 0;
    logic [11:0] se_r[5] = '{12'h3ff, 12'h000, 12'h500, 12'hf00, 12'h155};
    logic [9:0]  se_e[5] = '{10'h3ff, 10'h000, 10'h3ff, 10'h000, 10'h155};
    logic [11:0] df_r[6] = '{12'h300, 12'hc00, 12'h000, 12'h1ff, 12'he00, 12'he70};
    logic [9:0]  df_e[6] = '{10'h1ff, 10'h200, 10'h000, 10'h1ff, 10'h200, 10'h270};

    always #5 hclk = ~hclk;

    aris_top dut_u (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .conv_done_in(conv_done_in), .conv_raw(conv_raw), .conv_start(conv_start),
        .ref_source(ref_source), .internal_ref_on(internal_ref_on), .diff_mode(diff_mode),
        .pos_input(pos_input), .neg_input(neg_input), .gain(gain), .busy(busy), .irq(irq));

    aris_analog_model ana_u (.hclk(hclk), .hresetn(hresetn), .conv_start(conv_start),
        .dly(dly), .val(val), .conv_done_in(conv_done_in), .conv_raw(conv_raw));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    // entered and left just after a rising edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask : wr

    task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, x);
        chk(n, x, e);
    endtask : rdc

    task automatic res(input logic [9:0] e, input logic adj);
        rdc("result low", ARIS_OFF_RESULT_LOW, adj ? {24'h0, e[1:0], 6'h0} : {24'h0, e[7:0]});
        rdc("result high", ARIS_OFF_RESULT_HIGH, adj ? {24'h0, e[9:2]} : {30'h0, e[9:8]});
    endtask : res

    task automatic start(input logic [11:0] r, input logic [7:0] d);
        val <= r;
        dly <= d;
        wr(ARIS_OFF_CONTROL, 32'h1);
    endtask : start

    task automatic finish_conv;
        @(posedge hclk);
        while (busy !== 1'b0) @(posedge hclk);
    endtask : finish_conv

    task automatic route(input logic d, input logic [3:0] p, input logic [3:0] n,
                         input logic [1:0] g);
        repeat (2) @(posedge hclk);
        chk("route", {21'h0, diff_mode, pos_input, neg_input, 2'(gain)}, {21'h0, d, p, n, g});
    endtask : route

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        error_cnt++;
        print_verdict();
    end

    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk("ref reset", {30'h0, ref_source}, 32'h0);
        rdc("select", ARIS_OFF_INPUT_SELECT, 32'h0);
        rdc("status", ARIS_OFF_IRQ_STATUS, 32'h0);
        rdc("unmapped", 8'h40, 32'h0);
        wr(ARIS_OFF_INPUT_SELECT, 32'hff);
        rdc("select", ARIS_OFF_INPUT_SELECT, 32'hff);
        for (int i = 0; i < 4; i++) begin
            wr(ARIS_OFF_INPUT_SELECT, {24'h0, 2'(i), 6'h0});
            repeat (2) @(posedge hclk);
            chk("ref", {30'h0, ref_source}, 32'(i));
            chk("int ref", {31'h0, internal_ref_on}, {31'h0, 1'(i >> 1)});
        end
        $display("test select_and_reference done");
        wr(ARIS_OFF_INPUT_SELECT, 32'h03);
        route(1'b0, 4'h3, 4'h0, 2'h0);
        for (int i = 0; i < 5; i++) begin
            start(se_r[i], 8'h03);
            finish_conv();
            res(se_e[i], 1'b0);
        end
        wr(ARIS_OFF_INPUT_SELECT, 32'h20);
        res(10'h155, 1'b1);
        $display("test single_ended done");
        wr(ARIS_OFF_INPUT_SELECT, 32'hed);
        route(1'b1, 4'h3, 4'h2, 2'h1);
        for (int i = 0; i < 6; i++) begin
            start(df_r[i], 8'h02);
            finish_conv();
            res(df_e[i], 1'b1);
        end
        wr(ARIS_OFF_INPUT_SELECT, 32'hcd);
        res(10'h270, 1'b0);
        wr(ARIS_OFF_INPUT_SELECT, 32'h1a);
        route(1'b1, 4'h2, 4'h2, 2'h0);
        $display("test differential done");
        start(12'h0ff, 8'd40);
        wr(ARIS_OFF_INPUT_SELECT, 32'hbe);
        rdc("busy", ARIS_OFF_CONTROL, 32'h1);
        route(1'b1, 4'h2, 4'h2, 2'h0);
        chk("ref held", {30'h0, ref_source}, 32'h0);
        res(10'h270, 1'b1);
        finish_conv();
        route(1'b0, 4'h8, 4'h0, 2'h0);
        chk("ref applied", {30'h0, ref_source}, 32'h2);
        rdc("idle", ARIS_OFF_CONTROL, 32'h0);
        res(10'h0ff, 1'b1);
        $display("test deferred_update done");
        wr(ARIS_OFF_IRQ_ENABLE, 32'h1);
        @(posedge hclk);
        chk("irq pending", {31'h0, irq}, 32'h1);
        wr(ARIS_OFF_IRQ_CLEAR, 32'h1);
        @(posedge hclk);
        chk("irq cleared", {31'h0, irq}, 32'h0);
        rdc("clear reg", ARIS_OFF_IRQ_CLEAR, 32'h0);
        start(12'h001, 8'h04);
        finish_conv();
        chk("irq done", {31'h0, irq}, 32'h1);
        wr(ARIS_OFF_IRQ_ENABLE, 32'h0);
        @(posedge hclk);
        chk("irq masked", {31'h0, irq}, 32'h0);
        rdc("status", ARIS_OFF_IRQ_STATUS, 32'h1);
        wr(ARIS_OFF_IRQ_CLEAR, 32'h1);
        rdc("status", ARIS_OFF_IRQ_STATUS, 32'h0);
        $display("test interrupt done");
        ce <= 1'b0;
        repeat (2) @(posedge hclk);
        chk("ce stall", {31'h0, hreadyout}, 32'h0);
        ce <= 1'b1;
        rdc("select kept", ARIS_OFF_INPUT_SELECT, 32'hbe);
        $display("test clock_enable done");
        print_verdict();
    end
endmodule : aris_tb_top

`default_nettype wire
